// [rtl/fci_cfg.svh]
`ifndef FCI_CFG_SVH
`define FCI_CFG_SVH

`define FCI_ADDR_W 20
`define FCI_DATA_W 8
`define FCI_BLOCK_BYTES 65536
`define FCI_BLOCK_SHIFT 16
`define FCI_CNT_W 16

`define FCI_CLK_NS 10
`define FCI_T_READ_VALID_NS 400
`define FCI_T_WAKE_US 1
`define FCI_T_WE_LOW_NS 50
`define FCI_T_READ_ACC_NS 120
`define FCI_T_BUSY_LAT_NS 200

`define FCI_READ_VALID_CYC ((`FCI_T_READ_VALID_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_WAKE_CYC ((`FCI_T_WAKE_US * 1000 + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_WE_LOW_CYC ((`FCI_T_WE_LOW_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_READ_ACC_CYC ((`FCI_T_READ_ACC_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_BUSY_LAT_CYC ((`FCI_T_BUSY_LAT_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_SYNC_LAT_CYC 2

`define FCI_CODE_READ_ARRAY 8'h01
`define FCI_CODE_READ_STATUS 8'h02
`define FCI_CODE_PROGRAM 8'h03
`define FCI_CODE_ERASE 8'h04
`define FCI_CODE_CONFIRM 8'h05
`define FCI_CODE_SUSPEND 8'h06
`define FCI_CODE_RESUME 8'h07
`endif

// [rtl/fci_host.sv]
`include "fci_cfg.svh"
module fci_host #(
  parameter int WAKE_CYC = `FCI_WAKE_CYC,
  parameter int READ_VALID_CYC = `FCI_READ_VALID_CYC,
  parameter int WE_LOW_CYC = `FCI_WE_LOW_CYC,
  parameter int READ_ACC_CYC = `FCI_READ_ACC_CYC,
  parameter int BUSY_LAT_CYC = `FCI_BUSY_LAT_CYC,
  parameter logic [`FCI_DATA_W-1:0] CODE_READ_ARRAY = `FCI_CODE_READ_ARRAY,
  parameter logic [`FCI_DATA_W-1:0] CODE_READ_STATUS = `FCI_CODE_READ_STATUS,
  parameter logic [`FCI_DATA_W-1:0] CODE_PROGRAM = `FCI_CODE_PROGRAM,
  parameter logic [`FCI_DATA_W-1:0] CODE_ERASE = `FCI_CODE_ERASE,
  parameter logic [`FCI_DATA_W-1:0] CODE_CONFIRM = `FCI_CODE_CONFIRM,
  parameter logic [`FCI_DATA_W-1:0] CODE_SUSPEND = `FCI_CODE_SUSPEND,
  parameter logic [`FCI_DATA_W-1:0] CODE_RESUME = `FCI_CODE_RESUME
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic powerdown_req,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [2:0] cmd_op,
  input wire logic [`FCI_ADDR_W-1:0] cmd_addr,
  input wire logic [`FCI_DATA_W-1:0] cmd_data,
  output logic rsp_valid,
  output logic [`FCI_DATA_W-1:0] rsp_data,
  output logic device_busy,
  output logic [`FCI_ADDR_W-1:0] address_lines,
  output logic [`FCI_DATA_W-1:0] data_lines_o,
  output logic data_lines_oe,
  input wire logic [`FCI_DATA_W-1:0] data_lines_i,
  output logic chip_select_n,
  output logic out_enable_n,
  output logic write_strobe_n,
  output logic reset_powerdown_n,
  input wire logic op_done_flag_n
);

  ////////////////////////////////////////////////////////////////////////////////
  // Counts and helpers.

  // Reads and writes both wait for the longer of the two recovery times.
  localparam int WAKE_MAX = (WAKE_CYC > READ_VALID_CYC) ? WAKE_CYC : READ_VALID_CYC;
  localparam logic [`FCI_CNT_W-1:0] WAKE_CNT = `FCI_CNT_W'(WAKE_MAX - 1);
  localparam logic [`FCI_CNT_W-1:0] WE_CNT = `FCI_CNT_W'(WE_LOW_CYC - 1);
  localparam logic [`FCI_CNT_W-1:0] READ_CNT = `FCI_CNT_W'(READ_ACC_CYC + `FCI_SYNC_LAT_CYC - 1);
  localparam logic [`FCI_CNT_W-1:0] BUSY_CNT = `FCI_CNT_W'(BUSY_LAT_CYC - 1);

  function automatic logic [`FCI_CNT_W-1:0] dec(input logic [`FCI_CNT_W-1:0] v);
    dec = v - `FCI_CNT_W'(1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin inputs pass a two-stage synchroniser.

  logic [`FCI_DATA_W-1:0] dq_s;
  logic ready_s;

  fci_sync #(
    .WIDTH(`FCI_DATA_W + 1),
    .RST_VAL({1'b1, {`FCI_DATA_W{1'b0}}})
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({op_done_flag_n, data_lines_i}),
    .sync_out({ready_s, dq_s})
  );

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  fci_pkg::fci_regs_type q;
  fci_pkg::fci_regs_type d;
  logic cmd_fire;

  // Only a suspend may be issued while an operation still runs.
  assign cmd_ready = (q.st == fci_pkg::ST_IDLE) && !powerdown_req &&
                     (ready_s || (cmd_op == fci_pkg::OP_SUSPEND));
  assign cmd_fire = cmd_valid && cmd_ready;

  always_comb begin
    d = q;
    d.rsp_valid = 1'b0;
    unique case (q.st)
      fci_pkg::ST_PWRDN: begin
        d.rp_n = 1'b0;
        d.ce_n = 1'b1;
        d.oe_n = 1'b1;
        d.we_n = 1'b1;
        d.dq_oe = 1'b0;
        if (!powerdown_req) begin
          d.rp_n = 1'b1;
          d.cnt = WAKE_CNT;
          d.st = fci_pkg::ST_WAKE;
        end
      end
      fci_pkg::ST_WAKE: begin
        d.mode_array = 1'b1;
        if (powerdown_req) begin
          d.rp_n = 1'b0;
          d.st = fci_pkg::ST_PWRDN;
        end else if (q.cnt == '0) begin
          d.st = fci_pkg::ST_IDLE;
        end else begin
          d.cnt = dec(q.cnt);
        end
      end
      fci_pkg::ST_IDLE: begin
        if (powerdown_req) begin
          // Powerdown is taken only between commands so no write cycle is cut short.
          d.rp_n = 1'b0;
          d.st = fci_pkg::ST_PWRDN;
        end else if (cmd_fire) begin
          d.addr = cmd_addr;
          d.wd0 = CODE_READ_ARRAY;
          d.wd1 = cmd_data;
          d.wr_left = 2'd0;
          d.wr_second = 1'b0;
          d.do_read = 1'b0;
          d.wait_busy = 1'b0;
          unique case (cmd_op)
            fci_pkg::OP_READ: begin
              d.do_read = 1'b1;
              d.wr_left = q.mode_array ? 2'd0 : 2'd1;
              d.mode_array = 1'b1;
            end
            fci_pkg::OP_STATUS: begin
              d.do_read = 1'b1;
              d.wr_left = 2'd1;
              d.wd0 = CODE_READ_STATUS;
              d.mode_array = 1'b0;
            end
            fci_pkg::OP_PROGRAM: begin
              d.wr_left = 2'd2;
              d.wd0 = CODE_PROGRAM;
              d.wait_busy = 1'b1;
              d.mode_array = 1'b0;
            end
            fci_pkg::OP_ERASE: begin
              d.wr_left = 2'd2;
              // The upper address bits pick the single block that is erased.
              d.addr = {cmd_addr[`FCI_ADDR_W-1:`FCI_BLOCK_SHIFT], {`FCI_BLOCK_SHIFT{1'b0}}};
              d.wd0 = CODE_ERASE;
              d.wd1 = CODE_CONFIRM;
              d.mode_array = 1'b0;
            end
            fci_pkg::OP_SUSPEND: begin
              d.wr_left = 2'd1;
              d.wd0 = CODE_SUSPEND;
              d.wait_busy = 1'b1;
              d.mode_array = 1'b0;
            end
            fci_pkg::OP_RESUME: begin
              d.wr_left = 2'd1;
              d.wd0 = CODE_RESUME;
              d.mode_array = 1'b0;
            end
            default: begin
              d.wr_left = 2'd0;
            end
          endcase
          if (d.wr_left != 2'd0) begin
            d.ce_n = 1'b0;
            d.dq_oe = 1'b1;
            d.dq_o = d.wd0;
            d.st = fci_pkg::ST_WSETUP;
          end else if (d.do_read) begin
            d.ce_n = 1'b0;
            d.oe_n = 1'b0;
            d.cnt = READ_CNT;
            d.st = fci_pkg::ST_READ;
          end else begin
            d.rsp_valid = 1'b1;
            d.rsp_data = '0;
          end
        end
      end
      fci_pkg::ST_WSETUP: begin
        d.we_n = 1'b0;
        d.cnt = WE_CNT;
        d.st = fci_pkg::ST_WPULSE;
      end
      fci_pkg::ST_WPULSE: begin
        if (q.cnt == '0) begin
          // Address and data stay put across the rising strobe edge.
          d.we_n = 1'b1;
          d.st = fci_pkg::ST_WHOLD;
        end else begin
          d.cnt = dec(q.cnt);
        end
      end
      fci_pkg::ST_WHOLD: begin
        d.wr_left = q.wr_left - 2'd1;
        d.wr_second = 1'b1;
        if (q.wr_left == 2'd2) begin
          d.dq_o = q.wd1;
          d.st = fci_pkg::ST_WSETUP;
        end else if (q.do_read) begin
          // The host lets go of the data lines on the same edge that output enable falls.
          d.dq_oe = 1'b0;
          d.oe_n = 1'b0;
          d.cnt = READ_CNT;
          d.st = fci_pkg::ST_READ;
        end else begin
          d.dq_oe = 1'b0;
          d.ce_n = 1'b1;
          // Every write sequence not followed by a read waits out the flag latency, so a late busy flag cannot let a command in.
          d.cnt = BUSY_CNT;
          d.st = fci_pkg::ST_BUSY;
        end
      end
      fci_pkg::ST_READ: begin
        if (q.cnt == '0) begin
          d.rsp_data = dq_s;
          d.rsp_valid = 1'b1;
          d.ce_n = 1'b1;
          d.oe_n = 1'b1;
          d.st = fci_pkg::ST_IDLE;
        end else begin
          d.cnt = dec(q.cnt);
        end
      end
      fci_pkg::ST_BUSY: begin
        // The flag may fall late, so it is not trusted until the latency has passed.
        if (q.cnt != '0) begin
          d.cnt = dec(q.cnt);
        end else if (ready_s || !q.wait_busy) begin
          // Erase and resume answer without waiting for ready, so a suspend can still be issued.
          d.rsp_valid = 1'b1;
          d.rsp_data = '0;
          d.st = fci_pkg::ST_IDLE;
        end
      end
      default: begin
        d.st = fci_pkg::ST_PWRDN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: fci_pkg::ST_PWRDN, cnt: '0, wr_left: 2'd0, wr_second: 1'b0, do_read: 1'b0,
             wait_busy: 1'b0, mode_array: 1'b1, addr: '0, wd0: '0, wd1: '0, ce_n: 1'b1,
             oe_n: 1'b1, we_n: 1'b1, rp_n: 1'b0, dq_oe: 1'b0, dq_o: '0, rsp_valid: 1'b0,
             rsp_data: '0};
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign rsp_valid = q.rsp_valid;
  assign rsp_data = q.rsp_data;
  assign device_busy = !ready_s;
  assign address_lines = q.addr;
  assign data_lines_o = q.dq_o;
  assign data_lines_oe = q.dq_oe;
  assign chip_select_n = q.ce_n;
  assign out_enable_n = q.oe_n;
  assign write_strobe_n = q.we_n;
  assign reset_powerdown_n = q.rp_n;
endmodule

// [rtl/fci_pkg.sv]
`include "fci_cfg.svh"
package fci_pkg;
  typedef enum logic [7:0] {
    ST_PWRDN = 8'h01,
    ST_WAKE = 8'h02,
    ST_IDLE = 8'h04,
    ST_WSETUP = 8'h08,
    ST_WPULSE = 8'h10,
    ST_WHOLD = 8'h20,
    ST_READ = 8'h40,
    ST_BUSY = 8'h80
  } fci_state_type;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_STATUS = 3'h1,
    OP_PROGRAM = 3'h2,
    OP_ERASE = 3'h3,
    OP_SUSPEND = 3'h4,
    OP_RESUME = 3'h5
  } fci_op_type;

  typedef struct packed {
    fci_state_type st;
    logic [`FCI_CNT_W-1:0] cnt;
    logic [1:0] wr_left;
    logic wr_second;
    logic do_read;
    logic wait_busy;
    logic mode_array;
    logic [`FCI_ADDR_W-1:0] addr;
    logic [`FCI_DATA_W-1:0] wd0;
    logic [`FCI_DATA_W-1:0] wd1;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic rp_n;
    logic dq_oe;
    logic [`FCI_DATA_W-1:0] dq_o;
    logic rsp_valid;
    logic [`FCI_DATA_W-1:0] rsp_data;
  } fci_regs_type;
endpackage

// [rtl/fci_sync.sv]
module fci_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// [verification/fci_flash_model.sv]
`include "fci_cfg.svh"
module fci_flash_model (
  input wire logic [19:0] addr,
  input wire logic [7:0] din,
  output logic [7:0] dout,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic rp_n,
  output logic rdy,
  input wire logic [31:0] busy_ns
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [int];
  logic [7:0] last = 8'h00, pend = 8'h00, d;
  logic [19:0] a;
  logic st = 1'b0, susp = 1'b0, go = 1'b0, era = 1'b0, busy_m = 1'b0;
  realtime t_up = 0;
  assign rdy = !busy_m || susp || !rp_n;
  ////////////////////////////////////////
  // A released bus shows the inverse of its last value, so stale data never passes for a read.
  always @* begin
    if (!ce_n && !oe_n && rp_n) begin
      last = st ? {rdy, 7'h00} : (mem.exists(addr) ? mem[addr] : 8'hff);
      dout = last;
    end else dout = ~last;
  end
  always @(negedge rp_n) begin
    disable run;
    {busy_m, st, susp, go, pend} = 12'h000;
  end
  always @(posedge rp_n) t_up = $realtime;
  always @(posedge we_n) begin
    if (!ce_n && rp_n && $realtime - t_up >= 1000.0) begin
      st = (din != `FCI_CODE_READ_ARRAY);
      if (pend == `FCI_CODE_PROGRAM || pend == `FCI_CODE_ERASE) begin
        {era, a, d, go, pend} = {pend == `FCI_CODE_ERASE, addr, din, 1'b1, 8'h00};
      end else begin
        pend = din;
        if (din == `FCI_CODE_SUSPEND && busy_m) susp = 1'b1;
        if (din == `FCI_CODE_RESUME) susp = 1'b0;
      end
    end
  end
  always begin : run
    wait (go);
    {go, busy_m} = 2'b01;
    for (int i = 0; i < (era ? 10 * busy_ns : busy_ns); i++) begin
      #1;
      wait (!susp);
    end
    if (era) begin
      foreach (mem[k]) if (k[19:16] == a[19:16]) mem[k] = 8'hff;
    end else mem[a] = mem.exists(a) ? mem[a] & d : d;
    busy_m = 1'b0;
  end
endmodule

// [verification/fci_host_assertions.sv]
`include "fci_cfg.svh"
module fci_host_assertions #(
  parameter int WAKE_CYC = 100,
  parameter int READ_VALID_CYC = 40
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_ready,
  input wire logic device_busy,
  input wire logic [19:0] address_lines,
  input wire logic [7:0] data_lines_o,
  input wire logic data_lines_oe,
  input wire logic chip_select_n,
  input wire logic out_enable_n,
  input wire logic write_strobe_n,
  input wire logic reset_powerdown_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Saturates so a long run cannot wrap back into the wake window.
  logic [7:0] up_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) up_q <= 8'h00;
    else if (!reset_powerdown_n) up_q <= 8'h00;
    else if (up_q != 8'hff) up_q <= up_q + 8'h01;
  end
  ////////////////////////////////////////
  sequence s_pulse; !write_strobe_n [*5] ##1 write_strobe_n; endsequence
  sequence s_first; $fell(write_strobe_n) && $past(chip_select_n, 2) && data_lines_o == `FCI_CODE_PROGRAM; endsequence
  property p_wake; !write_strobe_n |-> up_q >= WAKE_CYC; endproperty
  property p_read_valid; !out_enable_n |-> up_q >= READ_VALID_CYC; endproperty
  property p_strobe; $fell(write_strobe_n) |-> s_pulse; endproperty
  property p_pair; s_first ##0 s_pulse |=> ##[0:12] $fell(write_strobe_n); endproperty
  property p_hold; $rose(write_strobe_n) |-> $stable(address_lines) && $stable(data_lines_o); endproperty
  property p_turn; !out_enable_n |-> !data_lines_oe && !chip_select_n; endproperty
  property p_deselect; chip_select_n |-> write_strobe_n; endproperty
  property p_powerdown; !reset_powerdown_n |-> chip_select_n; endproperty
  property p_busy; $fell(write_strobe_n) && device_busy |-> data_lines_o == `FCI_CODE_SUSPEND; endproperty
  property p_idle; cmd_ready |-> chip_select_n && write_strobe_n && out_enable_n; endproperty
  a_wake: assert property (p_wake) else $error("strobe inside wake time");
  a_read_valid: assert property (p_read_valid) else $error("read before outputs valid");
  a_strobe: assert property (p_strobe) else $error("strobe width wrong");
  a_pair: assert property (p_pair) else $error("program setup not followed by data write");
  a_hold: assert property (p_hold) else $error("address or data moved at strobe rise");
  a_turn: assert property (p_turn) else $error("host drives bus during read");
  a_deselect: assert property (p_deselect) else $error("strobe while deselected");
  a_powerdown: assert property (p_powerdown) else $error("select during powerdown");
  a_busy: assert property (p_busy) else $error("command written while busy");
  a_idle: assert property (p_idle) else $error("bus not idle while ready");
endmodule
bind fci_host fci_host_assertions #(.WAKE_CYC(WAKE_CYC), .READ_VALID_CYC(READ_VALID_CYC)) u_fci_host_assertions (
  .clk(clk), .rst_n(rst_n), .cmd_ready(cmd_ready), .device_busy(device_busy),
  .address_lines(address_lines), .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe),
  .chip_select_n(chip_select_n), .out_enable_n(out_enable_n), .write_strobe_n(write_strobe_n),
  .reset_powerdown_n(reset_powerdown_n));

// [verification/flash_command_bus_interface_tb.sv]
module flash_command_bus_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n, pd, cv, cr, rv, busy, dqoe, csn, oen, wen, rpn, rdy;
  logic [2:0] op;
  logic [19:0] ca, al;
  logic [7:0] cd, rd, dqo, dli, mdq, r;
  int bns, err_total = 0, checks = 0, seed = 48;
  logic [7:0] sh [int];
  always #5 clk = ~clk;
  assign dli = dqoe ? dqo : mdq;
  fci_host u_fci_host (.clk(clk), .rst_n(rst_n), .powerdown_req(pd), .cmd_valid(cv), .cmd_ready(cr), .cmd_op(op),
    .cmd_addr(ca), .cmd_data(cd), .rsp_valid(rv), .rsp_data(rd), .device_busy(busy), .address_lines(al),
    .data_lines_o(dqo), .data_lines_oe(dqoe), .data_lines_i(dli), .chip_select_n(csn), .out_enable_n(oen),
    .write_strobe_n(wen), .reset_powerdown_n(rpn), .op_done_flag_n(rdy));
  fci_flash_model u_fci_flash_model (.addr(al), .din(dli), .dout(mdq), .ce_n(csn), .oe_n(oen), .we_n(wen),
    .rp_n(rpn), .rdy(rdy), .busy_ns(bns));
  ////////////////////////////////////////
  function automatic logic [7:0] exp_rd(input logic [19:0] a);
    return sh.exists(a) ? sh[a] : 8'hff;
  endfunction
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic await(ref logic s, input logic v);
    int n = 0;
    while (s !== v && n < 30000) begin
      n++;
      @(negedge clk);
    end
    if (s !== v) err_total++;
  endtask
  // The request stays up until the edge that samples ready high.
  task automatic cmd(input logic [2:0] o, input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    {cv, op, ca, cd} <= {1'b1, o, a, d};
    @(negedge clk);
    await(cr, 1'b1);
    @(posedge clk);
    cv <= 1'b0;
    @(negedge clk);
    await(rv, 1'b1);
    r = rd;
  endtask
  ////////////////////////////////////////
  initial begin
    logic [19:0] a;
    logic [7:0] d;
    {rst_n, pd, cv, op, ca, cd} = 34'h0;
    bns = 50;
    repeat (2) @(negedge clk);
    check("reset pins", 8'({rpn, csn}), 8'h01);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (50) @(negedge clk);
    check("wake ready", 8'(cr), 8'h00);
    cmd(3'h0, 20'h12345, 8'h00);
    check("fresh read", r, 8'hff);
    for (int i = 0; i < 10; i++) begin
      a = i == 0 ? 20'h00000 : i == 1 ? 20'hfffff : 20'($random(seed));
      d = 8'($random(seed));
      bns = 20 + {$random(seed)} % 300;
      cmd(3'h2, a, d);
      check("program answer", r, 8'h00);
      sh[a] = exp_rd(a) & d;
      cmd(3'h0, a, 8'h00);
      check("read back", r, sh[a]);
    end
    cmd(3'h1, 20'h00000, 8'h00);
    check("status", r, 8'h80);
    cmd(3'h6, 20'h00000, 8'h00);
    check("unused op", r, 8'h00);
    bns = 400;
    cmd(3'h3, 20'hf1234, 8'h00);
    repeat (4) @(negedge clk);
    check("busy", 8'(busy), 8'h01);
    @(posedge clk);
    op <= 3'h0;
    @(negedge clk);
    check("ready while busy", 8'(cr), 8'h00);
    cmd(3'h4, 20'h00000, 8'h00);
    repeat (4) @(negedge clk);
    check("suspended", 8'(busy), 8'h00);
    cmd(3'h0, 20'h00000, 8'h00);
    check("other block", r, exp_rd(20'h00000));
    cmd(3'h5, 20'h00000, 8'h00);
    repeat (6) @(negedge clk);
    await(busy, 1'b0);
    foreach (sh[k]) if (k[19:16] == 4'hf) sh[k] = 8'hff;
    cmd(3'h0, 20'hfffff, 8'h00);
    check("erased", r, 8'hff);
    cmd(3'h0, 20'h00000, 8'h00);
    check("kept", r, exp_rd(20'h00000));
    @(posedge clk);
    pd <= 1'b1;
    repeat (10) @(negedge clk);
    check("powerdown", 8'(rpn), 8'h00);
    @(posedge clk);
    pd <= 1'b0;
    cmd(3'h0, 20'h00000, 8'h00);
    check("wake read", r, exp_rd(20'h00000));
    summarize();
  end
  initial begin
    #400us;
    err_total++;
    summarize();
  end
endmodule
